// file: gpt_pkg.sv
// Purpose: Constants and types shared by the general-purpose timer counter.
// Assumes: Registers sit in a 16-bit wide memory-mapped configuration region.
// Notes:   Offsets are byte addresses within that region.
package gpt_pkg;

	// ==========================================================
	// Register map
	localparam logic [11:0] GPT_OFS_CNT   = 12'hC7C;
	localparam logic [11:0] GPT_OFS_LIM_A = 12'hC7E;
	localparam logic [11:0] GPT_OFS_LIM_B = 12'hC80;
	localparam logic [11:0] GPT_OFS_CTL   = 12'hC7A;

	// ==========================================================
	// Control register field positions
	localparam int GPT_CTL_ENB  = 15;
	localparam int GPT_CTL_PENB = 14;
	localparam int GPT_CTL_MAX  = 5;
	localparam int GPT_CTL_PSC  = 3;
	localparam int GPT_CTL_EXT  = 2;
	localparam int GPT_CTL_ALT  = 1;
	localparam int GPT_CTL_CONT = 0;

	// ==========================================================
	// Reset values and timing
	localparam logic [15:0] GPT_RST_CNT   = 16'h0000;
	localparam logic [15:0] GPT_RST_LIM   = 16'h0000;
	localparam logic [15:0] GPT_ALL_ONES  = 16'hFFFF;
	localparam logic [1:0]  GPT_DIV_LAST  = 2'h3;

	typedef struct packed {
		logic en;
		logic ext;
		logic psc;
		logic alt;
		logic cont;
	} gpt_ctl_type;

	typedef enum logic [0:0] {
		GPT_PH_A = 1'b0,
		GPT_PH_B = 1'b1
	} gpt_phase_type;

endpackage : gpt_pkg

// file: gpt_timer.sv
// Purpose: 16-bit timer counter with single and alternate compare modes.
// Assumes: One 100 MHz clock, synchronous active-low reset, 16-bit register port.
// Notes:   Output pin is driven always; no interrupt logic here.
// Function
// - Single compare: count to limit A, return to zero, ignore limit B.
// - Single compare: output high while counting, low one cycle after maximum.
// - Alternate compare: count to A, zero, count to B, zero.
// - Alternate plus continuous gives repeating square wave set by both limits.
// - Stopped external clock freezes output and status; resume on new edges.
// - Noncontinuous: clear count, halt, clear enable at sequence end.
// - Continuous: reset count at A or B, keep counting.
// - One-shot alternate: A, reset, B, then clear count, enable, halt.
// - Internal source increments every fourth clock.
// - Prescale source increments on each companion timer maximum.
// - External source increments on input rising edge, at most quarter clock.
// - Count readable any time; hardware resets it at maximum.
// - Count writable any time; counting continues from written value.
// - Each increment compares count with active limit.
// - Active limit zero means count to all ones.
// - Nonzero active limit is the maximum count.
// - Maximum flag set at either limit; software clears by writing zero.
// - Limit B is a 16-bit second maximum for alternate mode.
module gpt_timer
	import gpt_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	input  wire logic [11:0] i_addr,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_wdata,
	output logic      [15:0] o_rdata,
	input  wire logic        i_prescale_tick,
	input  wire logic        i_timer_input_pin,
	output logic             o_timer_output_pin
);

	// ==========================================================
	// Registers
	logic [15:0]   count_r;
	logic [15:0]   lim_a_r;
	logic [15:0]   lim_b_r;
	gpt_ctl_type   ctl_r;
	logic          max_flag_r;
	gpt_phase_type phase_r;
	logic          pulse_r;
	logic [1:0]    div_r;
	logic [2:0]    pin_sync_r;
	logic [15:0]   rdata_r;

	// ==========================================================
	// Decode
	wire logic wr_cnt = i_wr && (i_addr == GPT_OFS_CNT);
	wire logic wr_la  = i_wr && (i_addr == GPT_OFS_LIM_A);
	wire logic wr_lb  = i_wr && (i_addr == GPT_OFS_LIM_B);
	wire logic wr_ctl = i_wr && (i_addr == GPT_OFS_CTL);

	// ==========================================================
	// Clock source selection
	wire logic div_tick = (div_r == GPT_DIV_LAST);
	// Two sync stages first; edge detect reads only stages two and three
	wire logic ext_rise = pin_sync_r[1] & ~pin_sync_r[2];
	wire logic src_tick = ctl_r.ext ? ext_rise
	                    : (ctl_r.psc ? i_prescale_tick : div_tick);
	wire logic inc      = ctl_r.en && src_tick;

	// ==========================================================
	// Compare
	wire logic [15:0] act_lim = (ctl_r.alt && phase_r == GPT_PH_B) ? lim_b_r : lim_a_r;
	wire logic [15:0] max_val = (act_lim == GPT_RST_LIM) ? GPT_ALL_ONES : act_lim;
	wire logic [15:0] cnt_inc = count_r + 16'h0001;
	wire logic        hit     = inc && (cnt_inc == max_val);
	wire logic        seq_end = hit && (!ctl_r.alt || phase_r == GPT_PH_B);
	wire logic        halt    = seq_end && !ctl_r.cont;

	wire logic [15:0] ctl_view = {ctl_r.en, 9'h000, max_flag_r, 1'b0,
	                              ctl_r.psc, ctl_r.ext, ctl_r.alt, ctl_r.cont};
	wire logic [15:0] rd_mux = (i_addr == GPT_OFS_CNT)   ? count_r
	                         : (i_addr == GPT_OFS_LIM_A) ? lim_a_r
	                         : (i_addr == GPT_OFS_LIM_B) ? lim_b_r
	                         : (i_addr == GPT_OFS_CTL)   ? ctl_view
	                         : 16'h0000;

	// ==========================================================
	// Sequential
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pin_sync_r <= 3'h0;
			div_r      <= 2'h0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], i_timer_input_pin};
			div_r      <= ctl_r.en ? div_r + 2'h1 : div_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			count_r <= GPT_RST_CNT;
			phase_r <= GPT_PH_A;
		end else if (wr_cnt) begin
			count_r <= i_wdata;
		end else if (hit) begin
			count_r <= GPT_RST_CNT;
			phase_r <= (ctl_r.alt && phase_r == GPT_PH_A) ? GPT_PH_B : GPT_PH_A;
		end else if (inc) begin
			count_r <= cnt_inc;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			lim_a_r <= GPT_RST_LIM;
			lim_b_r <= GPT_RST_LIM;
		end else begin
			if (wr_la) lim_a_r <= i_wdata;
			if (wr_lb) lim_b_r <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			ctl_r      <= '0;
			max_flag_r <= 1'b0;
		end else begin
			if (wr_ctl) begin
				ctl_r.ext  <= i_wdata[GPT_CTL_EXT];
				ctl_r.psc  <= i_wdata[GPT_CTL_PSC];
				ctl_r.alt  <= i_wdata[GPT_CTL_ALT];
				ctl_r.cont <= i_wdata[GPT_CTL_CONT];
			end
			// Hardware end of sequence beats a software enable write
			if (halt)
				ctl_r.en <= 1'b0;
			else if (wr_ctl && i_wdata[GPT_CTL_PENB])
				ctl_r.en <= i_wdata[GPT_CTL_ENB];
			// Set wins over a software clear in the same cycle
			if (hit)
				max_flag_r <= 1'b1;
			else if (wr_ctl && !i_wdata[GPT_CTL_MAX])
				max_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pulse_r            <= 1'b0;
			o_timer_output_pin <= 1'b1;
			rdata_r            <= 16'h0000;
		end else begin
			pulse_r <= hit && !ctl_r.alt;
			if (ctl_r.alt)
				o_timer_output_pin <= (phase_r == GPT_PH_A) ^ hit;
			else
				o_timer_output_pin <= !(hit);
			if (i_rd) rdata_r <= rd_mux;
		end
	end

	assign o_rdata = rdata_r;

	// ==========================================================
	// Checks
	property p_single_pulse;
		@(posedge i_clk) disable iff (!i_resetn)
		(hit && !ctl_r.alt) |=> !o_timer_output_pin ##1 (o_timer_output_pin || $past(hit));
	endproperty
	a_single_pulse: assert property (p_single_pulse) else $error("single pulse wrong");

	property p_alt_level;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctl_r.alt && !hit) |=> (o_timer_output_pin == ($past(phase_r) == GPT_PH_A));
	endproperty
	a_alt_level: assert property (p_alt_level) else $error("alternate level wrong");

	property p_hit_clears;
		@(posedge i_clk) disable iff (!i_resetn)
		(hit && !wr_cnt) |=> (count_r == 16'h0000);
	endproperty
	a_hit_clears: assert property (p_hit_clears) else $error("count not cleared");

	property p_oneshot_halt;
		@(posedge i_clk) disable iff (!i_resetn)
		halt |=> !ctl_r.en ##1 (count_r == 16'h0000 || $past(wr_cnt));
	endproperty
	a_oneshot_halt: assert property (p_oneshot_halt) else $error("no halt");

	property p_flag_set;
		@(posedge i_clk) disable iff (!i_resetn)
		hit |=> max_flag_r;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_disabled_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		(!ctl_r.en && !wr_cnt) |=> $stable(count_r);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("count moved");

	property p_internal_rate;
		@(posedge i_clk) disable iff (!i_resetn)
		(inc && !ctl_r.ext && !ctl_r.psc) |=> !inc [*3];
	endproperty
	a_internal_rate: assert property (p_internal_rate) else $error("rate too fast");

	property p_zero_limit;
		@(posedge i_clk) disable iff (!i_resetn)
		(inc && act_lim == 16'h0000 && count_r == 16'hFFFE) |-> hit;
	endproperty
	a_zero_limit: assert property (p_zero_limit) else $error("zero limit wrong");

	property p_write_load;
		@(posedge i_clk) disable iff (!i_resetn)
		wr_cnt |=> (count_r == $past(i_wdata));
	endproperty
	a_write_load: assert property (p_write_load) else $error("write not loaded");

	// ==========================================================
	// Alternate sequence steps and single-mode phase
	// A count write in the hit cycle wins and keeps the phase
	sequence s_end_a;
		hit && ctl_r.alt && phase_r == GPT_PH_A && !wr_cnt;
	endsequence

	sequence s_end_b;
		hit && ctl_r.alt && phase_r == GPT_PH_B && !wr_cnt;
	endsequence

	sequence s_stop_b;
		hit && ctl_r.alt && phase_r == GPT_PH_B && !wr_cnt && !ctl_r.cont;
	endsequence

	property p_a_to_b;
		@(posedge i_clk) disable iff (!i_resetn)
		s_end_a |=> (phase_r == GPT_PH_B) && !o_timer_output_pin;
	endproperty
	a_a_to_b: assert property (p_a_to_b) else $error("phase A end wrong");

	property p_b_to_a;
		@(posedge i_clk) disable iff (!i_resetn)
		s_end_b |=> (phase_r == GPT_PH_A) && o_timer_output_pin;
	endproperty
	a_b_to_a: assert property (p_b_to_a) else $error("phase B end wrong");

	property p_alt_stop;
		@(posedge i_clk) disable iff (!i_resetn)
		s_stop_b |=> !ctl_r.en && (count_r == GPT_RST_CNT) && (phase_r == GPT_PH_A);
	endproperty
	a_alt_stop: assert property (p_alt_stop) else $error("one-shot alternate no stop");

	property p_single_phase;
		@(posedge i_clk) disable iff (!i_resetn)
		(hit && !ctl_r.alt && !wr_cnt) |=> (phase_r == GPT_PH_A);
	endproperty
	a_single_phase: assert property (p_single_phase) else $error("limit B in use");

	// ==========================================================
	// Status, source and pin checks
	property p_pulse_mirror;
		@(posedge i_clk) disable iff (!i_resetn)
		pulse_r |-> !o_timer_output_pin;
	endproperty
	a_pulse_mirror: assert property (p_pulse_mirror) else $error("pulse not on pin");

	property p_cont_keeps;
		@(posedge i_clk) disable iff (!i_resetn)
		(seq_end && ctl_r.cont && !wr_ctl) |=> ctl_r.en;
	endproperty
	a_cont_keeps: assert property (p_cont_keeps) else $error("continuous mode halted");

	property p_flag_sticky;
		@(posedge i_clk) disable iff (!i_resetn)
		(max_flag_r && !wr_ctl) |=> max_flag_r;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hardware");

	property p_en_guard;
		@(posedge i_clk) disable iff (!i_resetn)
		(!halt && !(wr_ctl && i_wdata[GPT_CTL_PENB])) |=> $stable(ctl_r.en);
	endproperty
	a_en_guard: assert property (p_en_guard) else $error("enable moved");

	// Stalled external clock must leave count and flag alone
	property p_ext_stall;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctl_r.ext && !ext_rise && !wr_cnt && !wr_ctl)
			|=> $stable(count_r) && $stable(max_flag_r);
	endproperty
	a_ext_stall: assert property (p_ext_stall) else $error("moved without edge");

	property p_ext_step;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctl_r.en && ctl_r.ext && ext_rise && !hit && !wr_cnt)
			|=> (count_r == $past(count_r) + 16'h0001);
	endproperty
	a_ext_step: assert property (p_ext_step) else $error("edge not counted");

	property p_psc_step;
		@(posedge i_clk) disable iff (!i_resetn)
		(ctl_r.en && !ctl_r.ext && ctl_r.psc && i_prescale_tick && !hit && !wr_cnt)
			|=> (count_r == $past(count_r) + 16'h0001);
	endproperty
	a_psc_step: assert property (p_psc_step) else $error("prescale tick not counted");

	property p_read_count;
		@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == GPT_OFS_CNT) |=> (o_rdata == $past(count_r));
	endproperty
	a_read_count: assert property (p_read_count) else $error("count read wrong");

	property p_pin_hold;
		@(posedge i_clk) disable iff (!i_resetn)
		(!ctl_r.en && !$past(hit) && !$past(wr_ctl)) |=> $stable(o_timer_output_pin);
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin moved while disabled");

endmodule : gpt_timer

// file: gpt_pins.sv
// Purpose: Far-side model: external clock pin and companion timer tick.
// Assumes: Runs only while the bench raises i_run.
// Notes:   Pin stands low while stopped, as a halted source would.
module gpt_pins
	import gpt_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_run,
	output logic      o_pin,
	output logic      o_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] cnt_r;
	always_ff @(posedge i_clk) begin
		cnt_r <= i_run ? cnt_r + 7'h01 : 7'h00;
	end
	// Rising edge every 8 clocks, slower than a quarter clock
	assign o_pin  = i_run & cnt_r[2];
	assign o_tick = i_run & (cnt_r[3:0] == 4'hF);
endmodule : gpt_pins

// file: testbench.sv
// Purpose: Self-checking bench for the timer counter.
// Assumes: Inputs change on the falling edge only.
// Notes:   Windows of whole periods make output-level counts exact.
module testbench
	import gpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, run = 0;
	logic [11:0] i_addr = 12'h000;
	logic [15:0] i_wdata = 16'h0000, o_rdata, v0, v1;
	logic        pin, tick, tout;
	int          fail_count = 0, total_checks = 0, n;
	always #5 i_clk = ~i_clk;
	gpt_timer DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr),
		.i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_prescale_tick(tick),
		.i_timer_input_pin(pin), .o_timer_output_pin(tout));
	gpt_pins u_pins (.i_clk(i_clk), .i_run(run), .o_pin(pin), .o_tick(tick));
	// ==========================================================
	// Bus and check helpers
	task automatic cyc(input int k);
		repeat (k) @(negedge i_clk);
	endtask : cyc
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		i_addr = a;
		i_wdata = d;
		i_wr = 1;
		cyc(1);
		i_wr = 0;
		// Idle edge so a following call never re-raises the strobe in one step
		cyc(1);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		i_addr = a;
		i_rd = 1;
		cyc(1);
		i_rd = 0;
		d = o_rdata;
		cyc(1);
	endtask : rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic lvl(input int k, input logic want);
		n = 0;
		repeat (k) begin
			cyc(1);
			n += int'(tout === want);
		end
	endtask : lvl
	task automatic conclude;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		logic [11:0] ofs[5] = '{GPT_OFS_CNT, GPT_OFS_LIM_A, GPT_OFS_LIM_B, GPT_OFS_CTL, 12'h000};
		wr(12'h000, 16'hFFFF);
		foreach (ofs[i]) begin
			rd(ofs[i], v0);
			chk(v0, 16'h0000);
		end
	endtask : t_regs
	task automatic t_rate;
		wr(GPT_OFS_CTL, 16'hC001);
		rd(GPT_OFS_CNT, v0);
		cyc(39);
		rd(GPT_OFS_CNT, v1);
		chk(v1 - v0, 16'h000A);
		wr(GPT_OFS_CTL, 16'h4000);
		rd(GPT_OFS_CNT, v0);
		cyc(39);
		rd(GPT_OFS_CNT, v1);
		chk(v1, v0);
	endtask : t_rate
	task automatic t_single;
		wr(GPT_OFS_LIM_A, 16'h0005);
		wr(GPT_OFS_CNT, 16'h0000);
		wr(GPT_OFS_CTL, 16'hC001);
		cyc(20);
		lvl(200, 1'b0);
		chk(16'(n), 16'h000A);
		rd(GPT_OFS_CNT, v0);
		chk(16'(v0 < 16'h0005), 16'h0001);
	endtask : t_single
	task automatic t_alt;
		// Stop and clear first: a count above the new limit would wrap the full range
		wr(GPT_OFS_CTL, 16'h4000);
		wr(GPT_OFS_CNT, 16'h0000);
		wr(GPT_OFS_LIM_A, 16'h0003);
		wr(GPT_OFS_LIM_B, 16'h0005);
		wr(GPT_OFS_CTL, 16'hC003);
		cyc(40);
		lvl(320, 1'b1);
		chk(16'(n), 16'h0078);
		wr(GPT_OFS_CTL, 16'h4000);
		wr(GPT_OFS_CNT, 16'h0000);
		wr(GPT_OFS_CTL, 16'hC002);
		cyc(60);
		rd(GPT_OFS_CTL, v0);
		chk(v0 & 16'h8020, 16'h0020);
		rd(GPT_OFS_CNT, v0);
		chk(v0, 16'h0000);
		// Last halt left phase A, so B phase low lasts five ticks
		wr(GPT_OFS_CTL, 16'hC002);
		lvl(60, 1'b0);
		chk(16'(n), 16'h0014);
		wr(GPT_OFS_CTL, 16'h0000);
		rd(GPT_OFS_CTL, v0);
		chk(v0 & 16'h0020, 16'h0000);
	endtask : t_alt
	task automatic t_ext;
		wr(GPT_OFS_LIM_A, 16'h0000);
		wr(GPT_OFS_CTL, 16'hC005);
		run = 1;
		cyc(80);
		run = 0;
		cyc(10);
		rd(GPT_OFS_CNT, v0);
		chk(v0, 16'h000A);
		cyc(50);
		rd(GPT_OFS_CNT, v0);
		chk(v0, 16'h000A);
		wr(GPT_OFS_CNT, 16'h0000);
		wr(GPT_OFS_CTL, 16'hC009);
		run = 1;
		cyc(80);
		run = 0;
		cyc(5);
		rd(GPT_OFS_CNT, v0);
		chk(v0, 16'h0005);
		wr(GPT_OFS_CNT, 16'h1234);
		run = 1;
		cyc(16);
		run = 0;
		rd(GPT_OFS_CNT, v0);
		chk(v0, 16'h1235);
	endtask : t_ext
	task automatic t_wrap;
		wr(GPT_OFS_CTL, 16'h4000);
		wr(GPT_OFS_LIM_A, 16'h0000);
		wr(GPT_OFS_CNT, 16'hFFFC);
		wr(GPT_OFS_CTL, 16'hC000);
		cyc(30);
		rd(GPT_OFS_CNT, v0);
		chk(v0, 16'h0000);
		rd(GPT_OFS_CTL, v0);
		chk(v0 & 16'h8020, 16'h0020);
	endtask : t_wrap
	initial begin
		cyc(20);
		i_resetn = 1;
		t_regs();
		t_rate();
		t_single();
		t_alt();
		t_ext();
		t_wrap();
		conclude();
	end
	initial begin
		#50000;
		fail_count++;
		conclude();
	end
endmodule : testbench
